/* min_link_consts.svh */
// constants of the transition-minimised video link transmitter
// assumes inclusion by bare name from each design file that uses its constants
`ifndef MIN_LINK_CONSTS_SVH
`define MIN_LINK_CONSTS_SVH
`define DATA_W        8
`define CHAR_W        10
`define LANE_N        3
`define USER_N        3
`define BIT_RATIO     10
`define BIT_CNT_W     4
`define BIT_LAST      4'h9
`define CTRL_CODE_00  10'h354
`define CTRL_CODE_01  10'h0ab
`define CTRL_CODE_10  10'h154
`define CTRL_CODE_11  10'h2ab
`define IDLE_CHAR     10'h354
`define CLK_LANE_PAT  10'h01f
`define MIN_BLANK_CYC 4'ha
`define BLANK_CNT_W   4
`define BAL_HALF      4'h4
`endif

/* min_link_pkg.sv */
// shared types of the video link transmitter
// assumes min_link_consts.svh is on the include path
`include "min_link_consts.svh"
package min_link_pkg;
  typedef logic [`CHAR_W-1:0]        char_t;
  typedef char_t [`LANE_N-1:0]       lane_chars_t;
  typedef logic signed [4:0]         disp_t;
  typedef logic [`DATA_W-1:0]        byte_t;
  typedef struct packed {
    char_t chr;
    disp_t disp;
  } enc_res_t;
endpackage : min_link_pkg

/* lane_word_if.sv */
// character words passed from the pixel domain to the serialiser
// chars stay stable while req differs from ack
`timescale 1ns/10ps
interface lane_word_if;
  import min_link_pkg::*;
  lane_chars_t chars;
  logic        req;
  logic        ack;
  modport src (output chars, output req, input ack);
  modport snk (input chars, input req, output ack);
endinterface : lane_word_if

/* bit_sync.sv */
// two-flop level synchroniser
// assumes d is a level from another clock domain
`timescale 1ns/10ps
module bit_sync (
  // clock and reset
  input  wire logic clk,
  input  wire logic arst_n,
  // level
  input  wire logic d,
  output logic      q
);
  typedef struct packed {
    logic s1;
    logic s2;
  } sync_state_t;
  sync_state_t st_reg;
  sync_state_t st_next;

  always_comb begin
    st_next    = st_reg;
    st_next.s1 = d;
    st_next.s2 = st_reg.s1;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign q = st_reg.s2;
endmodule : bit_sync

/* link_serialiser.sv */
// bit-clock serialiser: three data lanes and the forwarded clock lane
// assumes serialClk is the bit clock, ten per pixel character
`timescale 1ns/10ps
`include "min_link_consts.svh"
module link_serialiser (
  // bit clock and reset
  input  wire logic     serialClk,
  input  wire logic     arst_n,
  // characters from the pixel domain
  lane_word_if.snk      words,
  // serial pairs and the starved flag
  output logic [`LANE_N-1:0] dataLanePos,
  output logic [`LANE_N-1:0] dataLaneNeg,
  output logic          linkClockPos,
  output logic          linkClockNeg,
  output logic          starved
);
  import min_link_pkg::*;
  typedef struct packed {
    lane_chars_t             shift;
    char_t                   clkShift;
    logic [`BIT_CNT_W-1:0]   bitCnt;
    logic                    ackT;
    logic                    starved;
  } ser_state_t;
  ser_state_t st_reg;
  ser_state_t st_next;
  logic       reqSync;

  bit_sync u_req_sync (
    .clk    (serialClk),
    .arst_n (arst_n),
    .d      (words.req),
    .q      (reqSync)
  );

  always_comb begin
    st_next = st_reg;
    if (st_reg.bitCnt == `BIT_LAST) begin
      st_next.bitCnt   = '0;
      st_next.clkShift = `CLK_LANE_PAT;
      if (reqSync != st_reg.ackT) begin
        st_next.shift   = words.chars;
        st_next.ackT    = ~st_reg.ackT;
        st_next.starved = 1'b0;
      end else begin
        // no fresh character: keep the line balanced with a blank code
        st_next.shift   = {`LANE_N{`IDLE_CHAR}};
        st_next.starved = 1'b1;
      end
    end else begin
      st_next.bitCnt   = st_reg.bitCnt + 1'b1;
      st_next.clkShift = st_reg.clkShift >> 1;
      for (int i = 0; i < `LANE_N; i++) begin
        st_next.shift[i] = st_reg.shift[i] >> 1;
      end
    end
  end

  always_ff @(posedge serialClk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= '{shift: {`LANE_N{`IDLE_CHAR}}, clkShift: `CLK_LANE_PAT,
                  bitCnt: '0, ackT: 1'b0, starved: 1'b1};
    end else begin
      st_reg <= st_next;
    end
  end

  assign words.ack    = st_reg.ackT;
  assign starved      = st_reg.starved;
  assign linkClockPos = st_reg.clkShift[0];
  assign linkClockNeg = ~st_reg.clkShift[0];
  for (genvar g = 0; g < `LANE_N; g++) begin : g_lane
    assign dataLanePos[g] = st_reg.shift[g][0];
    assign dataLaneNeg[g] = ~st_reg.shift[g][0];
  end
endmodule : link_serialiser

/* min_transition_video_link.sv */
// transition-minimised serial video link transmitter top
// Contract
// - data lanes run ten bits per character; clock lane carries pixel rate
// - each byte maps to a 10-bit transition-limited DC-balanced character
// - serialiser loads a 10-bit character in parallel and shifts it out
// - exactly three data lanes plus one forwarded clock lane
// - during blanking, control levels (not edges) go out as special codes
// - lanes 0 and 1 use 256 data codes plus 4 control codes; lane 2 uses only the 00 and 01 control codes
// - blanking emits one of four codes chosen by the two lane controls
// - second control low picks the first two codes, high the last two
// - active video sends the data character and ignores control inputs
// - each lane carries at most eight colour bits per pixel
// - three user control inputs ride the link with no fixed meaning
// assumes the controller drives pixels on clk_sys with a valid/ready handshake
// and that serialClk is the free-running bit clock of the link
`timescale 1ns/10ps
`include "min_link_consts.svh"
module min_transition_video_link (
  // pixel clock and reset
  input  wire logic                  clk_sys,
  input  wire logic                  arst_n,
  // link bit clock
  input  wire logic                  serialClk,
  // parallel pixel side
  input  wire logic                  pixValid,
  output logic                       pixReady,
  input  wire logic [23:0]           pixData,
  input  wire logic                  activeVideoQualifier,
  input  wire logic                  hsync,
  input  wire logic                  vsync,
  input  wire logic [`USER_N-1:0]    userCtrl,
  // status
  output logic                       blankTooShort,
  output logic                       linkStarved,
  // serial pairs
  output logic [`LANE_N-1:0]         dataLanePos,
  output logic [`LANE_N-1:0]         dataLaneNeg,
  output logic                       linkClockPos,
  output logic                       linkClockNeg
);
  import min_link_pkg::*;

  // pixel-domain state: capture stage, encoder disparity, handshake
  typedef struct packed {
    logic                      capValid;
    logic [23:0]               capData;
    logic                      capActive;
    logic [1:0]                capSync;
    logic [`USER_N-1:0]        capUser;
    logic [1:0]                heldSync;
    logic [`USER_N-1:0]        heldUser;
    disp_t [`LANE_N-1:0]       disp;
    lane_chars_t               chars;
    logic                      reqT;
    logic [`BLANK_CNT_W-1:0]   blankCnt;
    logic                      blankShort;
  } pix_state_t;

  pix_state_t st_reg;
  pix_state_t st_next;

  lane_word_if words ();

  logic                  ackSync;
  logic                  launch;
  logic                  idleLink;
  logic [`LANE_N-1:0][1:0] laneCtrl;
  // one element per lane, so each lane's encoder process owns its own element
  enc_res_t              encRes [`LANE_N];

  // number of ones in a byte
  function automatic logic [3:0] ones8(input byte_t v);
    logic [3:0] n;
    n = '0;
    for (int i = 0; i < `DATA_W; i++) begin
      n = n + {3'b000, v[i]};
    end
    return n;
  endfunction : ones8

  // first stage: xor or xnor chain chosen to cut transitions
  function automatic logic [8:0] min_trans(input byte_t d);
    logic [8:0] qm;
    logic [3:0] n1;
    logic       useXnor;
    n1      = ones8(d);
    useXnor = (n1 > `BAL_HALF) || ((n1 == `BAL_HALF) && !d[0]);
    qm[0]   = d[0];
    for (int i = 1; i < `DATA_W; i++) begin
      qm[i] = useXnor ? ~(qm[i-1] ^ d[i]) : (qm[i-1] ^ d[i]);
    end
    qm[8] = ~useXnor;
    return qm;
  endfunction : min_trans

  // second stage: conditional inversion against running disparity
  function automatic enc_res_t encode_byte(input byte_t d, input disp_t cnt);
    enc_res_t   r;
    logic [8:0] qm;
    disp_t      n1;
    disp_t      n0;
    disp_t      diff;
    qm   = min_trans(d);
    n1   = disp_t'({1'b0, ones8(qm[7:0])});
    n0   = disp_t'(`DATA_W) - n1;
    diff = n1 - n0;
    if ((cnt == 0) || (n1 == n0)) begin
      r.chr  = {~qm[8], qm[8], (qm[8] ? qm[7:0] : ~qm[7:0])};
      r.disp = qm[8] ? (cnt + diff) : (cnt - diff);
    end else if (((cnt > 0) && (n1 > n0)) || ((cnt < 0) && (n0 > n1))) begin
      r.chr  = {1'b1, qm[8], ~qm[7:0]};
      r.disp = cnt + disp_t'({qm[8], 1'b0}) - diff;
    end else begin
      r.chr  = {1'b0, qm[8], qm[7:0]};
      r.disp = cnt - disp_t'({~qm[8], 1'b0}) + diff;
    end
    return r;
  endfunction : encode_byte

  // out-of-band code from the two control levels of a lane
  function automatic char_t ctrl_char(input logic [1:0] c);
    char_t k;
    unique case (c)
      2'b00: k = `CTRL_CODE_00;
      2'b01: k = `CTRL_CODE_01;
      2'b10: k = `CTRL_CODE_10;
      2'b11: k = `CTRL_CODE_11;
    endcase
    return k;
  endfunction : ctrl_char

  bit_sync u_ack_sync (
    .clk    (clk_sys),
    .arst_n (arst_n),
    .d      (words.ack),
    .q      (ackSync)
  );

  // the word register may be reused only after the bit domain took it
  assign idleLink = (st_reg.reqT == ackSync);
  assign launch   = st_reg.capValid && idleLink;
  assign pixReady = !st_reg.capValid || launch;

  // lane control pairs: sync on lane 0, user controls on lanes 1 and 2
  always_comb begin
    laneCtrl[0] = {st_reg.heldSync[1], st_reg.heldSync[0]};
    laneCtrl[1] = st_reg.heldUser[1:0];
    laneCtrl[2] = {1'b0, st_reg.heldUser[2]};
    if (!st_reg.capActive) begin
      // blank levels count from this very cycle, not the previous blank
      laneCtrl[0] = {st_reg.capSync[1], st_reg.capSync[0]};
      laneCtrl[1] = st_reg.capUser[1:0];
      laneCtrl[2] = {1'b0, st_reg.capUser[2]};
    end
  end

  for (genvar g = 0; g < `LANE_N; g++) begin : g_enc
    always_comb begin
      if (st_reg.capActive) begin
        encRes[g] = encode_byte(st_reg.capData[g*`DATA_W +: `DATA_W],
                                st_reg.disp[g]);
      end else begin
        encRes[g].chr  = ctrl_char(laneCtrl[g]);
        encRes[g].disp = '0;
      end
    end
  end

  always_comb begin
    st_next            = st_reg;
    st_next.blankShort = 1'b0;
    if (pixValid && pixReady) begin
      st_next.capValid  = 1'b1;
      st_next.capData   = pixData;
      st_next.capActive = activeVideoQualifier;
      st_next.capSync   = {vsync, hsync};
      st_next.capUser   = userCtrl;
    end else if (launch) begin
      st_next.capValid = 1'b0;
    end
    if (launch) begin
      for (int i = 0; i < `LANE_N; i++) begin
        st_next.chars[i] = encRes[i].chr;
        st_next.disp[i]  = encRes[i].disp;
      end
      st_next.reqT = ~st_reg.reqT;
      if (!st_reg.capActive) begin
        // control changes are honoured only in blanking
        st_next.heldSync = st_reg.capSync;
        st_next.heldUser = st_reg.capUser;
        if (st_reg.blankCnt != `MIN_BLANK_CYC) begin
          st_next.blankCnt = st_reg.blankCnt + 1'b1;
        end
      end else begin
        // a blank shorter than the minimum is flagged, not corrected
        st_next.blankShort = (st_reg.blankCnt != '0) &&
                             (st_reg.blankCnt < `MIN_BLANK_CYC);
        st_next.blankCnt   = '0;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      st_reg       <= '0;
      st_reg.chars <= {`LANE_N{`IDLE_CHAR}};
    end else begin
      st_reg <= st_next;
    end
  end

  assign words.chars   = st_reg.chars;
  assign words.req     = st_reg.reqT;
  assign blankTooShort = st_reg.blankShort;

  link_serialiser u_ser (
    .serialClk    (serialClk),
    .arst_n       (arst_n),
    .words        (words.snk),
    .dataLanePos  (dataLanePos),
    .dataLaneNeg  (dataLaneNeg),
    .linkClockPos (linkClockPos),
    .linkClockNeg (linkClockNeg),
    .starved      (linkStarved)
  );
endmodule : min_transition_video_link

/* min_link_props.sv */
// port checker of the video link transmitter
// assumes arst_n clears both the pixel and the bit clock domain
`timescale 1ns/10ps
`include "min_link_consts.svh"
module min_link_props (
  // clocks and reset
  input wire logic              clk_sys,
  input wire logic              arst_n,
  input wire logic              serialClk,
  // pixel side
  input wire logic              pixValid,
  input wire logic              pixReady,
  input wire logic              blankTooShort,
  // serial side
  input wire logic              linkStarved,
  input wire logic [`LANE_N-1:0] dataLanePos,
  input wire logic [`LANE_N-1:0] dataLaneNeg,
  input wire logic              linkClockPos,
  input wire logic              linkClockNeg
);
  sequence clkHighHalf;
    linkClockPos [*5];
  endsequence
  sequence clkLowHalf;
    !linkClockPos [*5];
  endsequence
  // idle code starts 0,0,1 on every lane, LSB first
  sequence idleStart;
    (dataLanePos == 3'h0) ##1 (dataLanePos == 3'h0) ##1 (dataLanePos == 3'h7);
  endsequence
  lane_pair_a: assert property (@(posedge serialClk) disable iff (!arst_n)
    dataLaneNeg == ~dataLanePos) else $error("data pair not complementary");
  clk_pair_a: assert property (@(posedge serialClk) disable iff (!arst_n)
    linkClockNeg == !linkClockPos) else $error("clock pair not complementary");
  clk_char_a: assert property (@(posedge serialClk) disable iff (!arst_n)
    $rose(linkClockPos) |-> clkHighHalf ##1 clkLowHalf ##1 linkClockPos)
    else $error("clock lane not five high five low");
  clk_low_a: assert property (@(posedge serialClk) disable iff (!arst_n)
    $fell(linkClockPos) |-> clkLowHalf ##1 clkHighHalf)
    else $error("clock lane low half wrong");
  idle_code_a: assert property (@(posedge serialClk) disable iff (!arst_n)
    $rose(linkClockPos) && linkStarved |-> idleStart)
    else $error("starved character is not the idle code");
  blank_pulse_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    blankTooShort |=> !blankTooShort) else $error("short blank flag longer than a cycle");
  ready_back_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    !pixReady |-> ##[1:24] pixReady) else $error("pixel side stalled too long");
  ready_drop_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    $fell(pixReady) |-> $past(pixValid)) else $error("ready fell with no pixel taken");
endmodule : min_link_props
bind min_transition_video_link min_link_props min_link_props_i (
  .clk_sys(clk_sys), .arst_n(arst_n), .serialClk(serialClk), .pixValid(pixValid),
  .pixReady(pixReady), .blankTooShort(blankTooShort), .linkStarved(linkStarved),
  .dataLanePos(dataLanePos), .dataLaneNeg(dataLaneNeg), .linkClockPos(linkClockPos),
  .linkClockNeg(linkClockNeg));

/* link_rx_model.sv */
// receiving end of the link: frames characters on the forwarded clock lane
// assumes lanes and clock lane are launched together, LSB first
`timescale 1ns/10ps
`include "min_link_consts.svh"
module link_rx_model (
  // link clock and reset
  input  wire logic               serialClk,
  input  wire logic               arst_n,
  // serial lanes
  input  wire logic [`LANE_N-1:0] dataLanePos,
  input  wire logic               linkClockPos,
  // recovered characters
  output min_link_pkg::lane_chars_t rxChars,
  output logic                    rxValid
);
  import min_link_pkg::*;
  char_t              clkSh;
  lane_chars_t        laneSh;
  logic [`LANE_N-1:0] smpEarly;
  logic [`LANE_N-1:0] smpMid;
  logic [`LANE_N-1:0] smpLate;
  logic               locked;
  // three sampling phases per bit; once they agree only the middle one stays on
  always @(posedge serialClk) begin
    #2;
    if (!locked) smpEarly <= dataLanePos;
    #8;
    if (!locked) smpLate <= dataLanePos;
  end
  always @(negedge serialClk) smpMid <= dataLanePos;
  // framing comes only from the forwarded clock, never from a local rate
  always_ff @(posedge serialClk or negedge arst_n) begin
    if (!arst_n) begin
      clkSh <= '0;
      laneSh <= '0;
      locked <= 1'b0;
    end else begin
      clkSh <= {linkClockPos, clkSh[9:1]};
      if (smpEarly === smpMid && smpMid === smpLate) locked <= 1'b1;
      for (int i = 0; i < `LANE_N; i++) laneSh[i] <= {smpMid[i], laneSh[i][9:1]};
    end
  end
  // all lanes framed by the one clock pattern, so no lane may lead another
  assign rxValid = (clkSh == `CLK_LANE_PAT);
  assign rxChars = laneSh;
endmodule : link_rx_model

/* tb.sv */
// self-checking bench: pixel source, receiver model and character checks
// assumes one pixel per valid/ready handshake and idle chars flagged starved
`timescale 1ns/10ps
`include "min_link_consts.svh"
module tb;
  import min_link_pkg::*;
  typedef struct {logic act; logic [23:0] d; logic [4:0] c;} note_t;
  logic        clk_sys, serialClk, arst_n, pixValid, pixReady, activeVideoQualifier;
  logic        hsync, vsync, blankTooShort, linkStarved, linkClockPos, linkClockNeg, rxValid;
  logic [23:0] pixData, rxPix;
  logic [2:0]  userCtrl, dataLanePos, dataLaneNeg;
  logic [9:0]  stvSh;
  logic [4:0]  ctlNow;
  logic [31:0] rnd;
  lane_chars_t rxChars, expChars;
  note_t       q[$];
  note_t       nt;
  int          n_fail, checked, nShort, cyc, n;
  int          disp[3];
  min_transition_video_link min_transition_video_link_i (.clk_sys(clk_sys), .arst_n(arst_n),
    .serialClk(serialClk), .pixValid(pixValid), .pixReady(pixReady), .pixData(pixData),
    .activeVideoQualifier(activeVideoQualifier), .hsync(hsync), .vsync(vsync),
    .userCtrl(userCtrl), .blankTooShort(blankTooShort), .linkStarved(linkStarved),
    .dataLanePos(dataLanePos), .dataLaneNeg(dataLaneNeg), .linkClockPos(linkClockPos),
    .linkClockNeg(linkClockNeg));
  link_rx_model link_rx_model_i (.serialClk(serialClk), .arst_n(arst_n),
    .dataLanePos(dataLanePos), .linkClockPos(linkClockPos), .rxChars(rxChars),
    .rxValid(rxValid));
  function automatic logic [31:0] nextRnd(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nextRnd
  function automatic logic [7:0] dec(input logic [9:0] c);
    logic [7:0] d;
    logic [7:0] o;
    d = c[9] ? ~c[7:0] : c[7:0];
    o[0] = d[0];
    for (int i = 1; i < 8; i++) o[i] = c[8] ? d[i] ^ d[i-1] : ~(d[i] ^ d[i-1]);
    return o;
  endfunction : dec
  function automatic logic [9:0] code(input logic [1:0] c);
    return (c == 2'h0) ? `CTRL_CODE_00 : (c == 2'h1) ? `CTRL_CODE_01 :
           (c == 2'h2) ? `CTRL_CODE_10 : `CTRL_CODE_11;
  endfunction : code
  task automatic check(input string what, input logic [29:0] seen, input logic [29:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic test_done();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : test_done
  // offer a pixel and hold it until taken; ready is read at the falling edge
  task automatic send(input logic act, input logic [23:0] d, input logic [4:0] ctl);
    int k;
    pixValid <= 1'b1;
    activeVideoQualifier <= act;
    pixData <= d;
    if (!act) ctlNow = ctl;
    {userCtrl, vsync, hsync} <= ctlNow;
    k = 0;
    do begin
      @(negedge clk_sys);
      k++;
    end while (pixReady !== 1'b1 && k < 50);
    @(posedge clk_sys);
    q.push_back('{act, d, ctlNow});
  endtask : send
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  initial begin
    serialClk = 1'b0;
    #3.7;
    forever #6 serialClk = ~serialClk;
  end
  always @(posedge clk_sys) begin
    cyc++;
    if (blankTooShort === 1'b1) nShort++;
    if (cyc == 5000) begin
      n_fail++;
      test_done();
    end
  end
  // starved characters carry no pixel and are skipped
  always @(posedge serialClk) begin
    stvSh <= {linkStarved, stvSh[9:1]};
    if (rxValid === 1'b1 && stvSh[5] === 1'b0) begin
      if (q.size() == 0) check("spare character", 30'h0, 30'h1);
      else begin
        nt = q.pop_front();
        if (nt.act) begin
          rxPix = {dec(rxChars[2]), dec(rxChars[1]), dec(rxChars[0])};
          check("data", {6'h0, rxPix}, {6'h0, nt.d});
          for (int i = 0; i < 3; i++) begin
            disp[i] += 2 * $countones(rxChars[i]) - 10;
            check("balance", (disp[i] <= 20 && disp[i] >= -20), 30'h1);
          end
        end else begin
          disp = '{0, 0, 0};
          expChars = {code({1'b0, nt.c[4]}), code(nt.c[3:2]), code(nt.c[1:0])};
          check("control", rxChars, expChars);
        end
      end
    end
  end
  initial begin
    {pixValid, activeVideoQualifier, hsync, vsync, userCtrl, pixData} = '0;
    {n_fail, checked, nShort, cyc} = '0;
    disp = '{0, 0, 0};
    ctlNow = '0;
    rnd = 32'h00013cae;
    arst_n = 1'b0;
    repeat (6) @(posedge clk_sys);
    arst_n <= 1'b1;
    @(posedge clk_sys);
    for (int i = 0; i < 12; i++) begin
      rnd = nextRnd(rnd);
      send(1'b1, rnd[23:0], 5'h0);
    end
    for (int i = 0; i < 32; i++) send(1'b0, 24'h0, i[4:0]);
    for (int i = 0; i < 40; i++) send(1'b1, (i < 20) ? 24'h000000 : 24'hffffff, 5'h0);
    // active, a three-pixel blank, then active again: exactly one short-blank pulse
    for (int i = 0; i < 20; i++) send(!(i > 11 && i < 15), 24'ha5c3e1, 5'h1f);
    pixValid <= 1'b0;
    n = 0;
    while (q.size() != 0 && n < 400) begin
      @(posedge clk_sys);
      n++;
    end
    check("queue drained", q.size() == 0, 30'h1);
    check("short blank pulses", nShort, 30'h1);
    test_done();
  end
endmodule : tb
